// file: tas_alarm_ctl.sv
// standby, one-shot conversion control and temperature alarm outputs
// assumes a serial engine giving single-cycle register strobes and an adc handshake
// Notes on behaviour
// - config bit 6 high puts device in standby; low means continuous conversion
// - entering standby aborts running conversion, no result stored, registers stay reachable
// - one-shot register write in standby runs one conversion, then back to standby
// - data written to one-shot register is ignored; the write alone triggers
// - limit writes in standby are compared against stored temperature, may raise alarm
// - alarm output is maskable; overtemperature trip never is
// - alarm asserts above high limit or at or below low limit
// - alarm held until alert response read, condition gone and status cleared
// - trip output low while temperature above trip limit
// - trip releases itself at trip limit minus hysteresis
// - hysteresis resets to ten degrees, one degree per step, writable
// - multipurpose pin selectable as alarm or as second trip output
// - second trip asserts above high limit, unmaskable, releases like primary trip
// - second trip uses the same hysteresis as primary trip
// - alert response read answered with own address, then alarm may release
`timescale 1ns/100ps
`default_nettype none
module tas_alarm_ctl #(
    parameter int TEMP_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output var  logic [7:0]        reg_rdata,
    input  wire logic              ara_done,
    output logic                   ara_respond,
    output logic                   conv_start,
    output logic                   conv_abort,
    output logic                   adc_enable,
    input  wire logic              conv_done,
    input  wire logic [TEMP_W-1:0] conv_data,
    output logic                   overtemp_trip_n_o,
    output logic                   overtemp_trip_n_oe,
    output logic                   alarm_pin_o,
    output var  logic              alarm_pin_oe
);
    if (TEMP_W != 8)
        $error("TEMP_W must be 8 to match the byte-wide registers");

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] temp;
    logic [7:0] config_r;
    logic [7:0] high_lim;
    logic [7:0] low_lim;
    logic [7:0] trip_lim;
    logic [7:0] hyst;
    logic [7:0] status;
    logic       wr_lim;
    logic       wr_cfg;
    logic       oneshot_wr;
    logic       status_rd;
    logic       standby;
    logic       conv_accept;

    assign wr_lim     = reg_wr_en && (reg_addr == tas_pkg::TAS_OFS_HIGH
                        || reg_addr == tas_pkg::TAS_OFS_LOW || reg_addr == tas_pkg::TAS_OFS_TRIP);
    assign wr_cfg     = reg_wr_en && reg_addr == tas_pkg::TAS_OFS_CONFIG;
    assign oneshot_wr = reg_wr_en && reg_addr == tas_pkg::TAS_OFS_ONESHOT;
    assign status_rd  = reg_rd_en && reg_addr == tas_pkg::TAS_OFS_STATUS;
    assign standby    = config_r[tas_pkg::TAS_CFG_STANDBY];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            config_r <= tas_pkg::TAS_RST_CONFIG;
            high_lim <= tas_pkg::TAS_RST_HIGH;
            low_lim  <= tas_pkg::TAS_RST_LOW;
            trip_lim <= tas_pkg::TAS_RST_TRIP;
            hyst     <= tas_pkg::TAS_RST_HYST;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == tas_pkg::TAS_OFS_CONFIG)
                config_r <= reg_wdata;
            else if (reg_addr == tas_pkg::TAS_OFS_HIGH)
                high_lim <= reg_wdata;
            else if (reg_addr == tas_pkg::TAS_OFS_LOW)
                low_lim <= reg_wdata;
            else if (reg_addr == tas_pkg::TAS_OFS_TRIP)
                trip_lim <= reg_wdata;
            else if (reg_addr == tas_pkg::TAS_OFS_HYST)
                hyst <= reg_wdata;
        end
    end

    // one-shot reads back as zero; its data never lands anywhere
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd_en)
        begin
            if (reg_addr == tas_pkg::TAS_OFS_TEMP)
                reg_rdata <= temp;
            else if (reg_addr == tas_pkg::TAS_OFS_STATUS)
                reg_rdata <= status;
            else if (reg_addr == tas_pkg::TAS_OFS_CONFIG)
                reg_rdata <= config_r;
            else if (reg_addr == tas_pkg::TAS_OFS_HIGH)
                reg_rdata <= high_lim;
            else if (reg_addr == tas_pkg::TAS_OFS_LOW)
                reg_rdata <= low_lim;
            else if (reg_addr == tas_pkg::TAS_OFS_TRIP)
                reg_rdata <= trip_lim;
            else if (reg_addr == tas_pkg::TAS_OFS_HYST)
                reg_rdata <= hyst;
            else
                reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // conversion control
    // ****************************************
    tas_pkg::tas_conv_state_t state;
    logic                     oneshot;

    assign conv_start  = state == tas_pkg::TAS_IDLE && (!standby || oneshot_wr);
    assign conv_abort  = state == tas_pkg::TAS_CONV && standby && !oneshot;
    assign conv_accept = state == tas_pkg::TAS_CONV && conv_done && !conv_abort;
    // a one-shot start must lift the inhibit in its own cycle, else the adc ignores it
    assign adc_enable  = !standby || state == tas_pkg::TAS_CONV || conv_start;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state   <= tas_pkg::TAS_IDLE;
            oneshot <= 1'b0;
        end
        else
        begin
            case (state)
                tas_pkg::TAS_IDLE:
                begin
                    if (conv_start)
                    begin
                        state   <= tas_pkg::TAS_CONV;
                        oneshot <= standby;
                    end
                end
                tas_pkg::TAS_CONV:
                begin
                    if (conv_done || conv_abort)
                    begin
                        state   <= tas_pkg::TAS_IDLE;
                        oneshot <= 1'b0;
                    end
                end
                default:
                    state <= tas_pkg::TAS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            temp <= tas_pkg::TAS_RST_TEMP;
        else if (conv_accept)
            temp <= conv_data;
    end

    // ****************************************
    // limit evaluation and alarm
    // ****************************************
    logic eval_q;
    logic hi_now;
    logic lo_now;
    logic trip_now;
    logic out_cond;
    logic alarm;

    // compare one cycle after the update so the new values are in place
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            eval_q <= 1'b0;
        else
            eval_q <= conv_accept || wr_lim;
    end

    assign hi_now   = $signed(temp) > $signed(high_lim);
    assign lo_now   = $signed(temp) <= $signed(low_lim);
    assign trip_now = $signed(temp) > $signed(trip_lim);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            out_cond <= 1'b0;
        else if (eval_q)
            out_cond <= hi_now || lo_now;
    end

    // a new event on the read cycle survives the clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            status <= tas_pkg::TAS_RST_STATUS;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (eval_q && ((i == tas_pkg::TAS_ST_HIGH && hi_now)
                    || (i == tas_pkg::TAS_ST_LOW && lo_now)
                    || (i == tas_pkg::TAS_ST_TRIP && trip_now)))
                    status[i] <= 1'b1;
                else if (status_rd)
                    status[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            alarm <= 1'b0;
        else if (eval_q && (hi_now || lo_now))
            alarm <= 1'b1;
        else if (ara_done && !out_cond && !status[tas_pkg::TAS_ST_HIGH]
                 && !status[tas_pkg::TAS_ST_LOW])
            alarm <= 1'b0;
    end

    // ****************************************
    // trip comparators and pins
    // ****************************************
    tas_cmp_if #(.W(TEMP_W)) pri_if ();
    tas_cmp_if #(.W(TEMP_W)) sec_if ();

    assign pri_if.temp  = temp;
    assign pri_if.limit = trip_lim;
    assign pri_if.hyst  = hyst;
    assign pri_if.eval  = eval_q;
    assign sec_if.temp  = temp;
    assign sec_if.limit = high_lim;
    assign sec_if.hyst  = hyst;
    assign sec_if.eval  = eval_q;

    tas_hyst_cmp #(.W(TEMP_W)) u_pri_cmp (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cmp     (pri_if)
    );
    tas_hyst_cmp #(.W(TEMP_W)) u_sec_cmp (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cmp     (sec_if)
    );

    // open drain: data low, enable means pulling the wire down
    assign overtemp_trip_n_o  = 1'b0;
    assign overtemp_trip_n_oe = pri_if.active;
    assign alarm_pin_o        = 1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            alarm_pin_oe <= 1'b0;
        else if (config_r[tas_pkg::TAS_CFG_PIN2])
            alarm_pin_oe <= sec_if.active;
        else
            alarm_pin_oe <= alarm && !config_r[tas_pkg::TAS_CFG_MASK];
    end

    // masked or repurposed pin gives no alert to answer for
    assign ara_respond = alarm_pin_oe && !config_r[tas_pkg::TAS_CFG_PIN2];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    standby_hold_a: assert property (standby && state == tas_pkg::TAS_IDLE && !oneshot_wr
        |=> state == tas_pkg::TAS_IDLE)
        else $error("conversion started in standby without trigger");
    run_restart_a: assert property (!standby && state == tas_pkg::TAS_IDLE |-> conv_start)
        else $error("no conversion started in normal mode");
    abort_keep_a: assert property (conv_abort |=> temp == $past(temp) && state == tas_pkg::TAS_IDLE)
        else $error("aborted conversion changed temperature");
    oneshot_start_a: assert property (standby && state == tas_pkg::TAS_IDLE && oneshot_wr
        |-> conv_start ##1 oneshot)
        else $error("one-shot write did not start a conversion");
    oneshot_back_a: assert property (state == tas_pkg::TAS_CONV && oneshot && conv_done && standby
        |=> state == tas_pkg::TAS_IDLE ##1 state == tas_pkg::TAS_IDLE)
        else $error("device did not return to standby");
    limit_alarm_a: assert property ((reg_wr_en && reg_addr == tas_pkg::TAS_OFS_HIGH
        && $signed(reg_wdata) < $signed(temp) && !config_r[tas_pkg::TAS_CFG_MASK]
        && !config_r[tas_pkg::TAS_CFG_PIN2]) ##1 (!wr_cfg && !conv_accept && !wr_lim)[*2]
        |=> alarm_pin_oe)
        else $error("limit write did not raise alarm");
    mask_block_a: assert property (config_r[tas_pkg::TAS_CFG_MASK] && !config_r[tas_pkg::TAS_CFG_PIN2]
        |=> !alarm_pin_oe)
        else $error("masked alarm reached the pin");
    alarm_hold_a: assert property (alarm && !ara_done |=> alarm)
        else $error("alarm released without alert response");
    ara_clear_a: assert property (ara_done && alarm && !out_cond && status[1:0] == 2'b00 && !eval_q
        |=> !alarm)
        else $error("serviced alarm not released");
    pin2_follow_a: assert property (config_r[tas_pkg::TAS_CFG_PIN2]
        |=> alarm_pin_oe == $past(sec_if.active))
        else $error("second trip pin does not follow comparator");
    hyst_reset_a: assert property (disable iff (1'b0) !rst_n |=> hyst == tas_pkg::TAS_RST_HYST)
        else $error("hysteresis reset value wrong");

    oneshot_done_c: cover property (oneshot && conv_accept);
    abort_seen_c: cover property (conv_abort);
    alarm_served_c: cover property (alarm ##[1:40] !alarm);
    pin2_trip_c: cover property (config_r[tas_pkg::TAS_CFG_PIN2] && alarm_pin_oe);
endmodule // tas_alarm_ctl
`default_nettype wire

// file: tas_pkg.sv
// shared constants for the temperature alarm and standby logic
// assumes an 8-bit register port driven by an external serial engine
package tas_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] TAS_OFS_TEMP    = 8'h00;
    localparam logic [7:0] TAS_OFS_STATUS  = 8'h01;
    localparam logic [7:0] TAS_OFS_CONFIG  = 8'h02;
    localparam logic [7:0] TAS_OFS_HIGH    = 8'h03;
    localparam logic [7:0] TAS_OFS_LOW     = 8'h04;
    localparam logic [7:0] TAS_OFS_ONESHOT = 8'h0F;
    localparam logic [7:0] TAS_OFS_TRIP    = 8'h20;
    localparam logic [7:0] TAS_OFS_HYST    = 8'h21;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [7:0] TAS_RST_TEMP    = 8'h00;
    localparam logic [7:0] TAS_RST_CONFIG  = 8'h00;
    localparam logic [7:0] TAS_RST_HIGH    = 8'h46;
    localparam logic [7:0] TAS_RST_LOW     = 8'h00;
    localparam logic [7:0] TAS_RST_TRIP    = 8'h55;
    localparam logic [7:0] TAS_RST_HYST    = 8'h0A;
    localparam logic [7:0] TAS_RST_STATUS  = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TAS_CFG_MASK    = 7;
    localparam int TAS_CFG_STANDBY = 6;
    localparam int TAS_CFG_PIN2    = 5;
    localparam int TAS_ST_HIGH     = 0;
    localparam int TAS_ST_LOW      = 1;
    localparam int TAS_ST_TRIP     = 2;

    typedef enum logic [1:0] {
        TAS_IDLE = 2'b00,
        TAS_CONV = 2'b01
    } tas_conv_state_t;
endpackage

// file: tas_cmp_if.sv
// carrier between the alarm controller and a hysteresis comparator
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface tas_cmp_if #(parameter int W = 8);
    logic signed [W-1:0] temp;
    logic signed [W-1:0] limit;
    logic        [W-1:0] hyst;
    logic                eval;
    logic                active;
    modport ctl (output temp, output limit, output hyst, output eval, input active);
    modport cmp (input temp, input limit, input hyst, input eval, output active);
endinterface
`default_nettype wire

// file: tas_hyst_cmp.sv
// trip comparator with release hysteresis, evaluated on eval strobes
// assumes limit and hyst are stable registers of the controller
`timescale 1ns/100ps
`default_nettype none
module tas_hyst_cmp #(
    parameter int W = 8
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    tas_cmp_if.cmp    cmp
);
    // ****************************************
    // comparator
    // ****************************************
    logic signed [W+1:0] temp_x;
    logic signed [W+1:0] rel_lvl;

    // two guard bits so limit minus hyst cannot wrap
    assign temp_x  = {{2{cmp.temp[W-1]}}, cmp.temp};
    assign rel_lvl = $signed({{2{cmp.limit[W-1]}}, cmp.limit}) - $signed({2'b00, cmp.hyst});

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cmp.active <= 1'b0;
        else if (cmp.eval)
        begin
            if (cmp.temp > cmp.limit)
                cmp.active <= 1'b1;
            else if (temp_x <= rel_lvl)
                cmp.active <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    trip_set_a: assert property (cmp.eval && cmp.temp > cmp.limit |=> cmp.active)
        else $error("trip not asserted above limit");
    trip_release_a: assert property (cmp.eval && temp_x <= rel_lvl && !(cmp.temp > cmp.limit)
        |=> !cmp.active)
        else $error("trip not released at limit minus hysteresis");
    trip_band_a: assert property (cmp.active && cmp.eval && temp_x > rel_lvl
        |=> cmp.active)
        else $error("trip released inside hysteresis band");
    trip_idle_a: assert property (!cmp.eval |=> $stable(cmp.active))
        else $error("trip changed without evaluation");
    trip_cycle_c: cover property (cmp.active ##[1:50] !cmp.active);
endmodule // tas_hyst_cmp
`default_nettype wire

// file: tas_adc_model.sv
// behavioural converter facing the alarm controller
// assumes the controller's start, abort and enable strobes on clk_sys
`timescale 1ns/100ps
`default_nettype none
module tas_adc_model #(
    parameter int CONV_CYC = 4
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    input  wire logic       adc_enable,
    input  wire logic [7:0] temp_in,
    output logic            conv_done,
    output logic [7:0]      conv_data
);
    int         cnt;
    logic       busy;
    logic [7:0] last;

    // outside the done cycle the data lines show garbage, never the result
    assign conv_data = conv_done ? last : ~last;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            busy      <= 1'b0;
            conv_done <= 1'b0;
            cnt       <= 0;
            last      <= 8'h00;
        end
        else
        begin
            conv_done <= 1'b0;
            if (conv_abort || !adc_enable)
            begin
                busy <= 1'b0;
            end
            else if (conv_start && !busy)
            begin
                busy <= 1'b1;
                cnt  <= CONV_CYC;
            end
            else if (busy)
            begin
                if (cnt == 1)
                begin
                    busy      <= 1'b0;
                    conv_done <= 1'b1;
                    last      <= temp_in;
                end
                else
                begin
                    cnt <= cnt - 1;
                end
            end
        end
    end
endmodule // tas_adc_model
`default_nettype wire

// file: tas_alarm_ctl_tb.sv
// self-checking bench for the standby, one-shot and alarm controller
// assumes tas_pkg and the converter model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tas_alarm_ctl_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic ara_done = 1'b0;
    logic ara_respond, conv_start, conv_abort, adc_enable, conv_done;
    logic [7:0] conv_data;
    logic [7:0] temp_in = 8'h19;
    logic trip_o, trip_oe, alarm_o, alarm_oe;
    logic [7:0] v;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    // pull-ups on both open-drain wires
    wire trip_wire_n = trip_oe ? trip_o : 1'b1;
    wire alarm_wire_n = alarm_oe ? alarm_o : 1'b1;

    tas_alarm_ctl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .ara_done(ara_done), .ara_respond(ara_respond),
        .conv_start(conv_start), .conv_abort(conv_abort), .adc_enable(adc_enable),
        .conv_done(conv_done), .conv_data(conv_data), .overtemp_trip_n_o(trip_o),
        .overtemp_trip_n_oe(trip_oe), .alarm_pin_o(alarm_o), .alarm_pin_oe(alarm_oe));
    tas_adc_model adc (.clk_sys(clk_sys), .rst_n(rst_n), .conv_start(conv_start),
        .conv_abort(conv_abort), .adc_enable(adc_enable), .temp_in(temp_in),
        .conv_done(conv_done), .conv_data(conv_data));

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    // ****************************************
    // bus and check tasks
    // ****************************************
    task wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask

    task ara;
        @(posedge clk_sys);
        #1;
        ara_done = 1'b1;
        @(posedge clk_sys);
        #1;
        ara_done = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // result stored, then a few cycles for compare and pin flops
    task wait_conv;
        int i;
        for (i = 0; i < 200 && conv_done !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 200)
            chk(8'h00, 8'h01);
        repeat (5) @(posedge clk_sys);
        #1;
    endtask

    task one_shot(input logic [7:0] t, input logic [7:0] d);
        temp_in = t;
        wr(tas_pkg::TAS_OFS_ONESHOT, d);
        wait_conv();
    endtask

    task settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task s_reset;
        rd(tas_pkg::TAS_OFS_HIGH, v);
        chk(v, 8'h46);
        rd(tas_pkg::TAS_OFS_TRIP, v);
        chk(v, 8'h55);
        rd(tas_pkg::TAS_OFS_HYST, v);
        chk(v, 8'h0A);
        rd(tas_pkg::TAS_OFS_CONFIG, v);
        chk(v, 8'h00);
        rd(8'h7E, v);
        chk(v, 8'h00);
    endtask

    task s_cont;
        wait_conv();
        wait_conv();
        rd(tas_pkg::TAS_OFS_TEMP, v);
        chk(v, 8'h19);
        chk({7'h00, alarm_wire_n}, 8'h01);
    endtask

    task s_standby;
        temp_in = 8'h1E;
        @(posedge clk_sys iff adc.busy);
        // lands while a conversion is running
        wr(tas_pkg::TAS_OFS_CONFIG, 8'h40);
        repeat (20) @(posedge clk_sys);
        #1;
        chk({7'h00, adc_enable}, 8'h00);
        rd(tas_pkg::TAS_OFS_TEMP, v);
        chk(v, 8'h19);
    endtask

    task s_oneshot;
        one_shot(8'h1E, 8'hA5);
        rd(tas_pkg::TAS_OFS_TEMP, v);
        chk(v, 8'h1E);
        chk({7'h00, adc_enable}, 8'h00);
        one_shot(8'h1D, 8'h00);
        rd(tas_pkg::TAS_OFS_TEMP, v);
        chk(v, 8'h1D);
        one_shot(8'h1E, 8'hFF);
    endtask

    task s_limit;
        wr(tas_pkg::TAS_OFS_HIGH, 8'h10);
        settle();
        chk({7'h00, alarm_wire_n}, 8'h00);
        chk({7'h00, ara_respond}, 8'h01);
        rd(tas_pkg::TAS_OFS_STATUS, v);
        chk(v, 8'h01);
        wr(tas_pkg::TAS_OFS_CONFIG, 8'hC0);
        settle();
        chk({7'h00, alarm_wire_n}, 8'h01);
        wr(tas_pkg::TAS_OFS_CONFIG, 8'h40);
        settle();
        chk({7'h00, alarm_wire_n}, 8'h00);
    endtask

    task s_service;
        ara();
        chk({7'h00, alarm_wire_n}, 8'h00);
        // fresh event leaves the status bit set after the condition ends
        wr(tas_pkg::TAS_OFS_HIGH, 8'h10);
        wr(tas_pkg::TAS_OFS_HIGH, 8'h46);
        ara();
        chk({7'h00, alarm_wire_n}, 8'h00);
        rd(tas_pkg::TAS_OFS_STATUS, v);
        chk(v, 8'h01);
        ara();
        chk({7'h00, alarm_wire_n}, 8'h01);
        chk({7'h00, ara_respond}, 8'h00);
        // low limit equal to the stored value counts as out of range
        wr(tas_pkg::TAS_OFS_LOW, 8'h1E);
        settle();
        chk({7'h00, alarm_wire_n}, 8'h00);
        wr(tas_pkg::TAS_OFS_LOW, 8'h00);
        rd(tas_pkg::TAS_OFS_STATUS, v);
        ara();
        chk({7'h00, alarm_wire_n}, 8'h01);
    endtask

    task s_trip;
        wr(tas_pkg::TAS_OFS_HYST, 8'h02);
        rd(tas_pkg::TAS_OFS_HYST, v);
        chk(v, 8'h02);
        wr(tas_pkg::TAS_OFS_TRIP, 8'h1C);
        settle();
        chk({7'h00, trip_wire_n}, 8'h00);
        rd(tas_pkg::TAS_OFS_STATUS, v);
        chk(v, 8'h04);
        wr(tas_pkg::TAS_OFS_CONFIG, 8'hC0);
        one_shot(8'h1B, 8'h11);
        chk({7'h00, trip_wire_n}, 8'h00);
        one_shot(8'h1A, 8'h22);
        chk({7'h00, trip_wire_n}, 8'h01);
    endtask

    task s_second;
        wr(tas_pkg::TAS_OFS_CONFIG, 8'hE0);
        wr(tas_pkg::TAS_OFS_HIGH, 8'h1C);
        one_shot(8'h1E, 8'h33);
        chk({7'h00, alarm_wire_n}, 8'h00);
        chk({7'h00, trip_wire_n}, 8'h00);
        one_shot(8'h1B, 8'h44);
        chk({7'h00, alarm_wire_n}, 8'h00);
        one_shot(8'h1A, 8'h55);
        chk({7'h00, alarm_wire_n}, 8'h01);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        s_reset();
        s_cont();
        s_standby();
        s_oneshot();
        s_limit();
        s_service();
        s_trip();
        s_second();
        wrap_up();
    end
endmodule // tas_alarm_ctl_tb
`default_nettype wire
